// File: ict_pkg.sv
// Purpose: Shared widths, bus cycle shape, operation and cost types, and
//          the clock and bus-cycle costs for the instruction timing model.
// Assumes: One core clock; every bus cycle is four clocks with no wait.
// Notes:   A cost is total clocks with its read and write bus cycles.
package ict_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CLK_W  = 10;
    localparam int CNT_W  = 6;
    localparam int REGN_W = 5;

    // ************************************************************
    // Bus cycle shape: clock k of a cycle holds states S2k and S2k+1
    // ************************************************************
    localparam logic [1:0]       PH_FIRST   = 2'h0;
    localparam logic [1:0]       PH_STROBE  = 2'h1;   // S2 rising edge
    localparam logic [1:0]       PH_WDATA   = 2'h2;   // S4, write data strobe
    localparam logic [1:0]       PH_ACK     = 2'h2;   // Wait states inserted here
    localparam logic [1:0]       PH_LAST    = 2'h3;   // Strobes end at S7
    localparam logic [CLK_W-1:0] BUS_CLOCKS = 10'h004;
    localparam logic [2:0]       SYNC_RST   = 3'h4;   // Ack idle, reset and halt held

    // Block register move, cost per register moved
    localparam logic [CLK_W-1:0] MV_W_CLK = 10'h004;
    localparam logic [CLK_W-1:0] MV_L_CLK = 10'h008;
    localparam logic [CNT_W-1:0] MV_W_BUS = 6'h01;
    localparam logic [CNT_W-1:0] MV_L_BUS = 6'h02;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [4:0] {
        CL_COND_BRANCH, CL_UNCOND_BRANCH, CL_BRANCH_SUB, CL_DEC_BRANCH,
        CL_BOUNDS_CHECK, CL_OVF_TRAP, CL_MOVE_M2R, CL_MOVE_R2M, CL_ABS_JUMP,
        CL_JUMP_SUB, CL_LOAD_EA, CL_PUSH_EA, CL_EXT_ARITH, CL_MEM_COMPARE,
        CL_DECIMAL, CL_IMM_STATUS, CL_STATUS_MOVE, CL_EXT_RESET, CL_EXC_RETURN,
        CL_SUB_RETURN, CL_HALT_WAIT, CL_FRAME_CREATE, CL_FRAME_REMOVE,
        CL_PERIPH_MOVE, CL_X_BUS_ERR, CL_X_IRQ, CL_X_GROUP, CL_X_OVF,
        CL_X_BOUNDS, CL_X_DIV0
    } ict_class_t;

    typedef enum logic [1:0] {ST_HELD, ST_IDLE, ST_RUN} ict_state_t;
    typedef enum logic [1:0] {K_READ, K_WRITE, K_INT} ict_kind_t;

    typedef struct packed {
        ict_class_t         cls;
        logic [1:0]         variant;
        logic               isLong;
        logic [REGN_W-1:0]  regCount;
        logic [CLK_W-1:0]   eaClocks;
        logic [CNT_W-1:0]   eaReads;
        logic [CNT_W-1:0]   eaWrites;
    } ict_op_t;

    typedef struct packed {
        logic [CLK_W-1:0] clocks;
        logic [CNT_W-1:0] reads;
        logic [CNT_W-1:0] writes;
    } ict_cost_t;

    // ************************************************************
    // Costs: clocks, reads, writes
    // ************************************************************
    localparam ict_cost_t C_BR_TAKEN = '{10'h00A, 6'h02, 6'h00};
    localparam ict_cost_t C_BR_NT_B  = '{10'h008, 6'h01, 6'h00};
    localparam ict_cost_t C_BR_NT_W  = '{10'h00C, 6'h02, 6'h00};
    localparam ict_cost_t C_BR_SUB   = '{10'h012, 6'h02, 6'h02};
    localparam ict_cost_t C_DB_TRUE  = '{10'h00C, 6'h02, 6'h00};
    localparam ict_cost_t C_DB_TAKEN = '{10'h00A, 6'h02, 6'h00};
    localparam ict_cost_t C_DB_EXPIR = '{10'h00E, 6'h03, 6'h00};
    localparam ict_cost_t C_CHK_OK   = '{10'h00A, 6'h01, 6'h00};
    localparam ict_cost_t C_OVF_OK   = '{10'h004, 6'h01, 6'h00};
    localparam ict_cost_t C_MV_M2R   = '{10'h00C, 6'h03, 6'h00};
    localparam ict_cost_t C_MV_R2M   = '{10'h008, 6'h02, 6'h00};
    localparam ict_cost_t C_JUMP     = '{10'h008, 6'h02, 6'h00};
    localparam ict_cost_t C_JUMP_SUB = '{10'h010, 6'h02, 6'h02};
    localparam ict_cost_t C_LOAD_EA  = '{10'h004, 6'h01, 6'h00};
    localparam ict_cost_t C_PUSH_EA  = '{10'h00C, 6'h01, 6'h02};
    localparam ict_cost_t C_XA_R_BW  = '{10'h004, 6'h01, 6'h00};
    localparam ict_cost_t C_XA_R_L   = '{10'h008, 6'h01, 6'h00};
    localparam ict_cost_t C_XA_M_BW  = '{10'h012, 6'h03, 6'h01};
    localparam ict_cost_t C_XA_M_L   = '{10'h01E, 6'h05, 6'h02};
    localparam ict_cost_t C_CMP_BW   = '{10'h00C, 6'h03, 6'h00};
    localparam ict_cost_t C_CMP_L    = '{10'h014, 6'h05, 6'h00};
    localparam ict_cost_t C_DEC_R    = '{10'h006, 6'h01, 6'h00};
    localparam ict_cost_t C_DEC_M    = '{10'h012, 6'h03, 6'h01};
    localparam ict_cost_t C_IMM_ST   = '{10'h014, 6'h03, 6'h00};
    localparam ict_cost_t C_ST_WR    = '{10'h00C, 6'h02, 6'h00};
    localparam ict_cost_t C_CC_WR    = '{10'h00C, 6'h01, 6'h00};
    localparam ict_cost_t C_ST_RD    = '{10'h006, 6'h01, 6'h00};
    localparam ict_cost_t C_EXT_RST  = '{10'h084, 6'h01, 6'h00};
    localparam ict_cost_t C_EXC_RET  = '{10'h014, 6'h05, 6'h00};
    localparam ict_cost_t C_SUB_RET  = '{10'h010, 6'h04, 6'h00};
    localparam ict_cost_t C_HALT     = '{10'h004, 6'h00, 6'h00};
    localparam ict_cost_t C_FR_MAKE  = '{10'h010, 6'h02, 6'h02};
    localparam ict_cost_t C_FR_DROP  = '{10'h00C, 6'h03, 6'h00};
    localparam ict_cost_t C_PM_WR_W  = '{10'h010, 6'h02, 6'h02};
    localparam ict_cost_t C_PM_WR_L  = '{10'h018, 6'h02, 6'h04};
    localparam ict_cost_t C_PM_RD_W  = '{10'h010, 6'h04, 6'h00};
    localparam ict_cost_t C_PM_RD_L  = '{10'h018, 6'h06, 6'h00};
    localparam ict_cost_t C_X_BUS    = '{10'h032, 6'h04, 6'h07};
    localparam ict_cost_t C_X_IRQ    = '{10'h02C, 6'h05, 6'h03};
    localparam ict_cost_t C_X_RESET  = '{10'h028, 6'h06, 6'h00};
    localparam ict_cost_t C_X_GROUP  = '{10'h022, 6'h04, 6'h03};
    localparam ict_cost_t C_X_OVF    = '{10'h022, 6'h05, 6'h03};
    localparam ict_cost_t C_X_BOUNDS = '{10'h028, 6'h04, 6'h03};
    localparam ict_cost_t C_X_DIV0   = '{10'h026, 6'h04, 6'h03};

endpackage : ict_pkg

// File: ict_instruction_timing.sv
// Purpose: Plays out the clock and bus-cycle timing of one operation of a
//          16-bit-bus core: reads, internal clocks, then writes.
// Assumes: Requests come from logic on clk; reset, halt and ack are pins.
// Notes:   Wait states stretch a bus cycle at its third clock until ack.
`timescale 1ns/1ps

module ict_instruction_timing (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Operation request
    input  wire logic                          start,
    input  wire ict_pkg::ict_op_t              op,
    // Processor pins, asynchronous
    input  wire logic                          resetIn_n,
    input  wire logic                          haltIn_n,
    input  wire logic                          busAck_n,
    // Bus strobes
    output logic                               address_strobe_n,
    output logic                               data_strobe_n,
    output logic                               readWrite,
    // Operation status
    output logic                               busy,
    output logic                               done,
    output logic [ict_pkg::CLK_W-1:0]          doneClocks,
    output logic [ict_pkg::CNT_W-1:0]          doneReads,
    output logic [ict_pkg::CNT_W-1:0]          doneWrites
);

    // ************************************************************
    // Cost lookup
    // ************************************************************

    // Cost of one operation; address time added only where it applies
    function automatic ict_pkg::ict_cost_t costOf(input ict_pkg::ict_op_t o);
        ict_pkg::ict_cost_t     c;
        logic [ict_pkg::CLK_W-1:0] perClk;
        logic [ict_pkg::CNT_W-1:0] perBus;
        c      = ict_pkg::C_HALT;
        perClk = o.isLong ? ict_pkg::MV_L_CLK : ict_pkg::MV_W_CLK;
        perBus = o.isLong ? ict_pkg::MV_L_BUS : ict_pkg::MV_W_BUS;
        case (o.cls)
            ict_pkg::CL_COND_BRANCH: begin
                c = o.variant[0] ? ict_pkg::C_BR_TAKEN :
                    (o.variant[1] ? ict_pkg::C_BR_NT_W : ict_pkg::C_BR_NT_B);
            end
            ict_pkg::CL_UNCOND_BRANCH: c = ict_pkg::C_BR_TAKEN;
            ict_pkg::CL_BRANCH_SUB:    c = ict_pkg::C_BR_SUB;
            ict_pkg::CL_DEC_BRANCH: begin
                c = o.variant[0] ? ict_pkg::C_DB_TRUE :
                    (o.variant[1] ? ict_pkg::C_DB_EXPIR : ict_pkg::C_DB_TAKEN);
            end
            ict_pkg::CL_BOUNDS_CHECK:  c = ict_pkg::C_CHK_OK;
            ict_pkg::CL_OVF_TRAP:      c = ict_pkg::C_OVF_OK;
            ict_pkg::CL_MOVE_M2R: begin
                c = ict_pkg::C_MV_M2R;
                c.clocks = c.clocks + perClk * ict_pkg::CLK_W'(o.regCount);
                c.reads  = c.reads + perBus * ict_pkg::CNT_W'(o.regCount);
            end
            ict_pkg::CL_MOVE_R2M: begin
                c = ict_pkg::C_MV_R2M;
                c.clocks = c.clocks + perClk * ict_pkg::CLK_W'(o.regCount);
                c.writes = perBus * ict_pkg::CNT_W'(o.regCount);
            end
            ict_pkg::CL_ABS_JUMP:      c = ict_pkg::C_JUMP;
            ict_pkg::CL_JUMP_SUB:      c = ict_pkg::C_JUMP_SUB;
            ict_pkg::CL_LOAD_EA:       c = ict_pkg::C_LOAD_EA;
            ict_pkg::CL_PUSH_EA:       c = ict_pkg::C_PUSH_EA;
            ict_pkg::CL_EXT_ARITH: begin
                if (o.variant[0]) begin
                    c = o.isLong ? ict_pkg::C_XA_M_L : ict_pkg::C_XA_M_BW;
                end else begin
                    c = o.isLong ? ict_pkg::C_XA_R_L : ict_pkg::C_XA_R_BW;
                end
            end
            ict_pkg::CL_MEM_COMPARE: begin
                c = o.isLong ? ict_pkg::C_CMP_L : ict_pkg::C_CMP_BW;
            end
            ict_pkg::CL_DECIMAL: begin
                c = o.variant[0] ? ict_pkg::C_DEC_M : ict_pkg::C_DEC_R;
            end
            ict_pkg::CL_IMM_STATUS:    c = ict_pkg::C_IMM_ST;
            ict_pkg::CL_STATUS_MOVE: begin
                case (o.variant)
                    2'h0:    c = ict_pkg::C_ST_WR;
                    2'h1:    c = ict_pkg::C_CC_WR;
                    default: c = ict_pkg::C_ST_RD;
                endcase
            end
            ict_pkg::CL_EXT_RESET:     c = ict_pkg::C_EXT_RST;
            ict_pkg::CL_EXC_RETURN:    c = ict_pkg::C_EXC_RET;
            ict_pkg::CL_SUB_RETURN:    c = ict_pkg::C_SUB_RET;
            ict_pkg::CL_HALT_WAIT:     c = ict_pkg::C_HALT;
            ict_pkg::CL_FRAME_CREATE:  c = ict_pkg::C_FR_MAKE;
            ict_pkg::CL_FRAME_REMOVE:  c = ict_pkg::C_FR_DROP;
            ict_pkg::CL_PERIPH_MOVE: begin
                if (o.variant[0]) begin
                    c = o.isLong ? ict_pkg::C_PM_RD_L : ict_pkg::C_PM_RD_W;
                end else begin
                    c = o.isLong ? ict_pkg::C_PM_WR_L : ict_pkg::C_PM_WR_W;
                end
            end
            ict_pkg::CL_X_BUS_ERR:     c = ict_pkg::C_X_BUS;
            ict_pkg::CL_X_IRQ:         c = ict_pkg::C_X_IRQ;
            ict_pkg::CL_X_GROUP:       c = ict_pkg::C_X_GROUP;
            ict_pkg::CL_X_OVF:         c = ict_pkg::C_X_OVF;
            ict_pkg::CL_X_BOUNDS:      c = ict_pkg::C_X_BOUNDS;
            ict_pkg::CL_X_DIV0:        c = ict_pkg::C_X_DIV0;
            default:                   c = ict_pkg::C_HALT;
        endcase
        // Address calculation time only counts for the marked entries
        if (o.cls == ict_pkg::CL_BOUNDS_CHECK || o.cls == ict_pkg::CL_X_BOUNDS ||
            o.cls == ict_pkg::CL_X_DIV0) begin
            c.clocks = c.clocks + o.eaClocks;
            c.reads  = c.reads + o.eaReads;
            c.writes = c.writes + o.eaWrites;
        end
        return c;
    endfunction : costOf

    // Reads go first, then internal clocks, then writes
    function automatic ict_pkg::ict_kind_t pickKind(
        input logic [ict_pkg::CNT_W-1:0] rd,
        input logic [ict_pkg::CLK_W-1:0] internal
    );
        if (rd != '0) begin
            return ict_pkg::K_READ;
        end else if (internal != '0) begin
            return ict_pkg::K_INT;
        end
        return ict_pkg::K_WRITE;
    endfunction : pickKind

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] syncA;
    logic [2:0] syncB;

    // Two flops per pin; only syncB is read by logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA <= ict_pkg::SYNC_RST;
            syncB <= ict_pkg::SYNC_RST;
        end else begin
            syncA <= {busAck_n, haltIn_n, resetIn_n};
            syncB <= syncA;
        end
    end

    logic pinsFree;
    logic ackSeen;
    assign pinsFree = syncB[0] & syncB[1];
    assign ackSeen  = ~syncB[2];

    // ************************************************************
    // Sequencer
    // ************************************************************
    ict_pkg::ict_state_t       state,    next_state;
    ict_pkg::ict_kind_t        kind,     next_kind;
    logic [1:0]                phase,    next_phase;
    logic [ict_pkg::CNT_W-1:0] rdLeft,   next_rdLeft;
    logic [ict_pkg::CNT_W-1:0] wrLeft,   next_wrLeft;
    logic [ict_pkg::CLK_W-1:0] intLeft,  next_intLeft;
    logic [ict_pkg::CLK_W-1:0] elapsed,  next_elapsed;
    logic [ict_pkg::CNT_W-1:0] rdCount,  next_rdCount;
    logic [ict_pkg::CNT_W-1:0] wrCount,  next_wrCount;
    logic                      next_as_n, next_ds_n, next_rw, next_busy, next_done;
    logic [ict_pkg::CLK_W-1:0] next_doneClocks;
    logic [ict_pkg::CNT_W-1:0] next_doneReads, next_doneWrites;

    // Next state of the operation in flight and of the strobes
    always_comb begin
        ict_pkg::ict_cost_t        ld;
        logic                      doLoad;
        logic                      endSlot;
        logic [ict_pkg::CNT_W-1:0] rdN;
        logic [ict_pkg::CNT_W-1:0] wrN;
        logic [ict_pkg::CLK_W-1:0] intN;
        ld              = costOf(op);
        doLoad          = 1'b0;
        endSlot         = 1'b0;
        rdN             = rdLeft;
        wrN             = wrLeft;
        intN            = intLeft;
        next_state      = state;
        next_kind       = kind;
        next_phase      = phase;
        next_rdLeft     = rdLeft;
        next_wrLeft     = wrLeft;
        next_intLeft    = intLeft;
        next_elapsed    = elapsed;
        next_rdCount    = rdCount;
        next_wrCount    = wrCount;
        next_done       = 1'b0;
        next_doneClocks = doneClocks;
        next_doneReads  = doneReads;
        next_doneWrites = doneWrites;
        case (state)
            ict_pkg::ST_HELD: begin
                if (pinsFree) begin
                    ld     = ict_pkg::C_X_RESET;
                    doLoad = 1'b1;
                end
            end
            ict_pkg::ST_IDLE: begin
                doLoad = start;
            end
            ict_pkg::ST_RUN: begin
                next_elapsed = elapsed + 1'b1;
                if (kind == ict_pkg::K_INT) begin
                    intN    = intLeft - 1'b1;
                    endSlot = 1'b1;
                end else if (phase != ict_pkg::PH_ACK || ackSeen) begin
                    if (phase == ict_pkg::PH_LAST) begin
                        endSlot = 1'b1;
                        if (kind == ict_pkg::K_READ) begin
                            rdN          = rdLeft - 1'b1;
                            next_rdCount = rdCount + 1'b1;
                        end else begin
                            wrN          = wrLeft - 1'b1;
                            next_wrCount = wrCount + 1'b1;
                        end
                    end else begin
                        next_phase = phase + 2'h1;
                    end
                end
                if (endSlot) begin
                    next_phase   = ict_pkg::PH_FIRST;
                    next_rdLeft  = rdN;
                    next_wrLeft  = wrN;
                    next_intLeft = intN;
                    next_kind    = pickKind(rdN, intN);
                    if (rdN == '0 && wrN == '0 && intN == '0) begin
                        next_state      = ict_pkg::ST_IDLE;
                        next_done       = 1'b1;
                        next_doneClocks = next_elapsed;
                        next_doneReads  = next_rdCount;
                        next_doneWrites = next_wrCount;
                    end
                end
            end
            default: next_state = ict_pkg::ST_HELD;
        endcase
        // Bus cycles are fixed at four clocks; the rest is internal time
        if (doLoad) begin
            next_state   = ict_pkg::ST_RUN;
            next_phase   = ict_pkg::PH_FIRST;
            next_rdLeft  = ld.reads;
            next_wrLeft  = ld.writes;
            next_intLeft = ld.clocks - ict_pkg::CLK_W'(ict_pkg::BUS_CLOCKS *
                           (ict_pkg::CLK_W'(ld.reads) + ict_pkg::CLK_W'(ld.writes)));
            next_kind    = pickKind(ld.reads, next_intLeft);
            next_elapsed = '0;
            next_rdCount = '0;
            next_wrCount = '0;
        end
        // Reset or halt held aborts anything and waits for both to clear
        if (!pinsFree) begin
            next_state = ict_pkg::ST_HELD;
            next_done  = 1'b0;
        end
        next_busy = (next_state != ict_pkg::ST_IDLE);
        // Address strobe low from S2 to S7, write data strobe from S4; negated over S0-S1 between cycles
        next_as_n = !(next_state == ict_pkg::ST_RUN && next_kind != ict_pkg::K_INT &&
                      next_phase >= ict_pkg::PH_STROBE);
        next_rw   = !(next_state == ict_pkg::ST_RUN && next_kind == ict_pkg::K_WRITE);
        next_ds_n = next_as_n | (!next_rw && next_phase < ict_pkg::PH_WDATA);
    end

    // Registers of the sequencer and its outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state            <= ict_pkg::ST_HELD;
            kind             <= ict_pkg::K_INT;
            phase            <= ict_pkg::PH_FIRST;
            rdLeft           <= '0;
            wrLeft           <= '0;
            intLeft          <= '0;
            elapsed          <= '0;
            rdCount          <= '0;
            wrCount          <= '0;
            address_strobe_n <= 1'b1;
            data_strobe_n    <= 1'b1;
            readWrite        <= 1'b1;
            busy             <= 1'b1;
            done             <= 1'b0;
            doneClocks       <= '0;
            doneReads        <= '0;
            doneWrites       <= '0;
        end else begin
            state            <= next_state;
            kind             <= next_kind;
            phase            <= next_phase;
            rdLeft           <= next_rdLeft;
            wrLeft           <= next_wrLeft;
            intLeft          <= next_intLeft;
            elapsed          <= next_elapsed;
            rdCount          <= next_rdCount;
            wrCount          <= next_wrCount;
            address_strobe_n <= next_as_n;
            data_strobe_n    <= next_ds_n;
            readWrite        <= next_rw;
            busy             <= next_busy;
            done             <= next_done;
            doneClocks       <= next_doneClocks;
            doneReads        <= next_doneReads;
            doneWrites       <= next_doneWrites;
        end
    end

endmodule : ict_instruction_timing

// File: ict_timing_props.sv
// Purpose: Port checks of bus strobes and cost reports.
// Assumes: One clock; rst_n synchronous, active low.
// Notes:   Wait states may only lengthen a bus cycle.
`timescale 1ns/1ps
module ict_timing_chk (
    // Clock, reset, strobes and status
    input wire logic clk, rst_n, address_strobe_n, data_strobe_n, readWrite, busy, done,
    // Cost report
    input wire logic [ict_pkg::CLK_W-1:0] doneClocks,
    input wire logic [ict_pkg::CNT_W-1:0] doneReads, doneWrites
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A write strobes data one clock after the address
    sequence s_write_ds;
        data_strobe_n ##1 !data_strobe_n;
    endsequence
    done_pulse_a: assert property (done |=> !done)
        else $error("done wider than one clock");
    done_busy_a: assert property (done |-> $past(busy))
        else $error("done without a running operation");
    idle_bus_a: assert property (!busy |-> address_strobe_n && data_strobe_n)
        else $error("strobe while idle");
    addr_span_a: assert property ($fell(address_strobe_n) |-> !address_strobe_n [*3])
        else $error("address strobe too short");
    read_data_a: assert property ($fell(address_strobe_n) && readWrite |-> !data_strobe_n)
        else $error("read data strobe late");
    write_data_a: assert property ($fell(address_strobe_n) && !readWrite |-> s_write_ds)
        else $error("write data strobe misplaced");
    strobe_pair_a: assert property ($rose(address_strobe_n) |-> data_strobe_n)
        else $error("strobes not negated together");
    cost_floor_a: assert property (done |-> doneClocks >= 4 * (doneReads + doneWrites))
        else $error("clocks below bus cycle time");
endmodule : ict_timing_chk
bind ict_instruction_timing ict_timing_chk u_chk (.clk(clk), .rst_n(rst_n), .done(done),
    .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n), .busy(busy),
    .readWrite(readWrite), .doneClocks(doneClocks), .doneReads(doneReads),
    .doneWrites(doneWrites));

// File: ict_bus_model.sv
// Purpose: Memory answering bus cycles, at once or three clocks late.
// Assumes: Acknowledge has a pull-up when not selected.
// Notes:   The fast memory grounds its acknowledge.
`timescale 1ns/1ps
module ict_bus_model (
    input wire logic clk, address_strobe_n, slow,
    output logic     busAck_n
);
    logic [1:0] age = 2'h0;
    // Clocks since the strobe fell, saturating
    always @(posedge clk) begin
        if (address_strobe_n) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    // Slow answer forces wait states
    assign busAck_n = slow ? !(!address_strobe_n && age == 2'h3) : 1'b0;
endmodule : ict_bus_model

// File: instruction_cycle_timing_tb.sv
// Purpose: Runs every operation kind and checks cost and bus traffic.
// Assumes: Inputs change at the falling edge.
// Notes:   Slow memory adds four wait clocks to every bus cycle.
`timescale 1ns/1ps
module instruction_cycle_timing_tb;
    logic clk = 0, rst_n = 0, start = 0, resetIn_n = 1, haltIn_n = 1, slow = 0, ps = 1, sl;
    logic busAck_n, address_strobe_n, data_strobe_n, readWrite, busy, done;
    logic [ict_pkg::CLK_W-1:0] doneClocks;
    logic [ict_pkg::CNT_W-1:0] doneReads, doneWrites, nRd = 0, nWr = 0;
    ict_pkg::ict_op_t op = '0;
    ict_pkg::ict_cost_t q[$], ex;
    logic qs[$];
    int n_fail = 0, checked = 0;
    logic [31:0] seed = 32'hc716;
    int tab[46][7] = '{'{0,1,0,0,10,2,0}, '{0,0,0,0,8,1,0}, '{0,2,0,0,12,2,0},
        '{1,0,0,0,10,2,0}, '{2,0,0,0,18,2,2}, '{3,1,0,0,12,2,0}, '{3,0,0,0,10,2,0},
        '{3,2,0,0,14,3,0}, '{4,0,0,0,18,3,0}, '{5,0,0,0,4,1,0}, '{6,0,0,16,76,19,0},
        '{6,0,1,3,36,9,0}, '{7,0,0,0,8,2,0}, '{7,0,1,4,40,2,8}, '{8,0,0,0,8,2,0},
        '{9,0,0,0,16,2,2}, '{10,0,0,0,4,1,0}, '{11,0,0,0,12,1,2}, '{12,0,0,0,4,1,0},
        '{12,0,1,0,8,1,0}, '{12,1,0,0,18,3,1}, '{12,1,1,0,30,5,2}, '{13,0,0,0,12,3,0},
        '{13,0,1,0,20,5,0}, '{14,0,0,0,6,1,0}, '{14,1,0,0,18,3,1}, '{15,0,0,0,20,3,0},
        '{16,0,0,0,12,2,0}, '{16,1,0,0,12,1,0}, '{16,2,0,0,6,1,0}, '{17,0,0,0,132,1,0},
        '{18,0,0,0,20,5,0}, '{19,0,0,0,16,4,0}, '{20,0,0,0,4,0,0}, '{21,0,0,0,16,2,2},
        '{22,0,0,0,12,3,0}, '{23,0,0,0,16,2,2}, '{23,0,1,0,24,2,4}, '{23,1,0,0,16,4,0},
        '{23,1,1,0,24,6,0}, '{24,0,0,0,50,4,7}, '{25,0,0,0,44,5,3}, '{26,0,0,0,34,4,3},
        '{27,0,0,0,34,5,3}, '{28,0,0,0,48,6,3}, '{29,0,0,0,46,6,3}};
    ict_instruction_timing dut (.clk(clk), .rst_n(rst_n), .start(start), .op(op),
        .resetIn_n(resetIn_n), .haltIn_n(haltIn_n), .busAck_n(busAck_n),
        .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
        .readWrite(readWrite), .busy(busy), .done(done), .doneClocks(doneClocks),
        .doneReads(doneReads), .doneWrites(doneWrites));
    ict_bus_model mem (.clk(clk), .address_strobe_n(address_strobe_n), .slow(slow),
        .busAck_n(busAck_n));
    always #2.5 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    // Random source for the memory speed
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic end_of_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // Bounded wait for idle; start may follow in the done cycle
    task automatic go(input int e[7]);
        int i;
        for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk);
        if (i == 400) begin
            n_fail++;
            end_of_test();
        end
        seed = lfsr(seed);
        slow = seed[0];
        op = '{ict_pkg::ict_class_t'(e[0]), e[1][1:0], e[2][0], e[3][4:0], 10'h008, 6'h02, 6'h00};
        q.push_back('{e[4][9:0], e[5][5:0], e[6][5:0]});
        qs.push_back(slow);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask : go
    // Count bus cycles on the strobes and compare each report
    always @(negedge clk) begin
        if (!address_strobe_n && ps) begin
            nRd = nRd + readWrite;
            nWr = nWr + !readWrite;
        end
        ps = address_strobe_n;
        if (done === 1'b1) begin
            check("queue", q.size() > 0, 1);
            ex = q.pop_front();
            sl = qs.pop_front();
            check("reads", {doneReads, nRd}, {ex.reads, ex.reads});
            check("writes", {doneWrites, nWr}, {ex.writes, ex.writes});
            if (sl) check("stretch", doneClocks, ex.clocks + 4 * (ex.reads + ex.writes));
            else check("clocks", doneClocks, ex.clocks);
            nRd = 0;
            nWr = 0;
        end
    end
    initial begin
        q.push_back('{10'h028, 6'h06, 6'h00});
        qs.push_back(1'b0);
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        foreach (tab[i]) go(tab[i]);
        // Halt and reset pins in mid-operation drop it and rerun reset entry
        go(tab[30]);
        repeat (20) @(negedge clk);
        haltIn_n  = 1'b0;
        resetIn_n = 1'b0;
        repeat (12) @(posedge clk);
        void'(q.pop_back());
        q.push_back('{10'h028, 6'h06, 6'h00});
        nRd = 0;
        nWr = 0;
        @(negedge clk);
        haltIn_n = 1'b1;
        repeat (3) @(negedge clk);
        resetIn_n = 1'b1;
        go(tab[33]);
        go(tab[0]);
        // Every noted result must have been reported before the verdict
        for (int i = 0; i < 400 && q.size() != 0; i++) @(negedge clk);
        check("drain", q.size(), 0);
        end_of_test();
    end
endmodule : instruction_cycle_timing_tb
